// File: design/tpwm_defines.svh
// Function
// - One shared 8-bit high-byte holding register
// - Low-byte write loads held high plus low
// - Low-byte read copies high byte into holder
// - 12-bit counter to B-reset top, ramp mode
// - Three modules, each with outputs A and B
// - One running mode shared by all modules
// - New settings take effect after cycle end; here the A reset takes effect at once
// - One-ramp on-times are reset minus set
// - One-ramp dead times from set/reset differences
// - Centered on-times and dead time formulas
// - Centered cycle is twice top plus one
// - Centered outputs centered, A reset unused
// - One-ramp frequency twice the centered frequency
// - Overlap allowed when guard disabled
// - Lock bit holds updates until cycle end; here they stay held until the lock bit is cleared
// - Lock covers config, mode, three compares; here the A reset bypasses the lock
// - Guard forbids both outputs active together
// - Per-output polarity, same timing
// - Software may stop early and restart fresh
// - Three emergency inputs force high-Z or inactive
// - Overlap guard on while disable bit zero
// - Clock select and 1/4/32/256 prescaler
`ifndef TPWM_DEFINES_SVH
`define TPWM_DEFINES_SVH

// Word indexes (byte address = index * 4)
`define TPWM_IDX_CTRL 5'h00
`define TPWM_IDX_CONFIG 5'h01
`define TPWM_IDX_OUTCFG 5'h02
`define TPWM_IDX_OUTMODE2 5'h03
`define TPWM_IDX_STATUS 5'h04
`define TPWM_IDX_CMP_BASE 5'h08
`define TPWM_IDX_CMP_LAST 5'h1B
`define TPWM_CMP_COUNT 10
`define TPWM_CMP_TOP 4'h9

// Control register fields
`define TPWM_CTRL_RUN 0
`define TPWM_CTRL_CENTERED 1
`define TPWM_CTRL_CYCLE_STOP 2
`define TPWM_CTRL_CLK_SEL 3
`define TPWM_CTRL_PRESC_LO 4
`define TPWM_CTRL_PRESC_HI 5

// Config register fields
`define TPWM_CFG_LOCK 0
`define TPWM_CFG_OVL_LO 1
`define TPWM_CFG_OVL_HI 3

// Prescaler terminal counts for divide by 1, 4, 32, 256
`define TPWM_PRESC_DIV1 8'h00
`define TPWM_PRESC_DIV4 8'h03
`define TPWM_PRESC_DIV32 8'h1F
`define TPWM_PRESC_DIV256 8'hFF

`define TPWM_RESET_CTRL 6'h00
`define TPWM_RESET_CONFIG 4'h0
`define TPWM_RESET_OUT 6'h00
`define TPWM_RESET_CMP 12'h000

`endif

// File: design/tpwm_pkg.sv
package tpwm_pkg;

  typedef enum logic [1:0] {
    TPWM_IDLE = 2'b00,
    TPWM_RUN = 2'b01,
    TPWM_DRAIN = 2'b11
  } tpwm_state_e;

  // Latched AHB address phase
  typedef struct packed {
    logic valid;
    logic write;
    logic [4:0] idx;
  } tpwm_ahb_s;

  // Decoded byte register of the compare area
  typedef struct packed {
    logic hit;
    logic hi;
    logic [3:0] k;
  } tpwm_dec_s;

endpackage

// File: design/tpwm_core.sv
// Design decisions made here: the AHB-Lite slave port and the address map.
`timescale 1ns/1ns
`include "tpwm_defines.svh"

module tpwm_core
  import tpwm_pkg::*;
(
  input wire logic SYS_CLK_I,
  input wire logic RST_I,
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  output logic [31:0] HRDATA_O,
  output logic HREADYOUT_O,
  output logic HRESP_O,
  input wire logic PLL_CLK_I,
  input wire logic [2:0] EMERGENCY_INPUT_I,
  input wire logic EMERGENCY_HIZ_CFG_I,
  output logic [2:0] STAGE_OUTPUT_A_O,
  output logic [2:0] STAGE_OUTPUT_A_OE_O,
  output logic [2:0] STAGE_OUTPUT_B_O,
  output logic [2:0] STAGE_OUTPUT_B_OE_O
);

  // Compare area decode, used by both the read and the write path
  function automatic tpwm_dec_s cmp_decode(input logic [4:0] idx);
    logic [4:0] rel;
    rel = idx - `TPWM_IDX_CMP_BASE;
    cmp_decode.hit = (idx >= `TPWM_IDX_CMP_BASE) && (idx <= `TPWM_IDX_CMP_LAST);
    cmp_decode.hi = rel[0];
    cmp_decode.k = rel[4:1];
  endfunction

  function automatic logic [7:0] presc_limit(input logic [1:0] sel);
    case (sel)
      2'b00: presc_limit = `TPWM_PRESC_DIV1;
      2'b01: presc_limit = `TPWM_PRESC_DIV4;
      2'b10: presc_limit = `TPWM_PRESC_DIV32;
      default: presc_limit = `TPWM_PRESC_DIV256;
    endcase
  endfunction

  // Software-visible registers
  logic [5:0] ctrl;
  logic [3:0] config_reg;
  logic [5:0] output_configuration;
  logic [5:0] output_mode_second;
  logic [7:0] temp_high;
  logic [11:0] cmp_reg [0:`TPWM_CMP_COUNT-1];

  // Working copies taken at cycle end
  logic [5:0] sh_outcfg;
  logic [5:0] sh_mode2;
  logic [11:0] sh_cmp [0:`TPWM_CMP_COUNT-1];

  tpwm_ahb_s dphase;
  tpwm_dec_s rdec;
  tpwm_dec_s wdec;
  logic addr_ok;
  logic acc_valid;

  tpwm_state_e state;
  tpwm_state_e next_state;
  logic [11:0] cnt;
  logic dir_up;
  logic [7:0] pre_cnt;
  logic tick;
  logic cyc_end;
  logic update_now;
  logic [11:0] top;

  logic pll_s1;
  logic pll_s2;
  logic pll_s3;
  logic [2:0] em_s1;
  logic [2:0] em_s2;
  logic hiz_s1;
  logic hiz_s2;
  logic emergency;

  logic [2:0] want_a;
  logic [2:0] want_b;

  // Single-cycle slave: no wait states, always OKAY
  assign HREADYOUT_O = 1'b1;
  assign HRESP_O = 1'b0;

  assign addr_ok = HADDR_I[31:7] == 25'h0000000;
  assign acc_valid = HSEL_I && HTRANS_I[1] && HREADY_I;
  assign rdec = cmp_decode(HADDR_I[6:2]);
  assign wdec = cmp_decode(dphase.idx);

  // Address phase capture for the write data phase
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      dphase <= '0;
    end else if (HREADY_I) begin
      dphase.valid <= acc_valid && addr_ok;
      dphase.write <= HWRITE_I;
      dphase.idx <= HADDR_I[6:2];
    end
  end

  // Read data is prepared in the address phase so it stands from a flop
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      HRDATA_O <= 32'h00000000;
    end else if (acc_valid && !HWRITE_I) begin
      HRDATA_O <= 32'h00000000;
      if (addr_ok) begin
        if (rdec.hit) begin
          if (rdec.hi) begin
            HRDATA_O[7:0] <= temp_high;
          end else begin
            HRDATA_O[7:0] <= cmp_reg[rdec.k][7:0];
          end
        end else begin
          case (HADDR_I[6:2])
            `TPWM_IDX_CTRL: HRDATA_O[5:0] <= ctrl;
            `TPWM_IDX_CONFIG: HRDATA_O[3:0] <= config_reg;
            `TPWM_IDX_OUTCFG: HRDATA_O[5:0] <= output_configuration;
            `TPWM_IDX_OUTMODE2: HRDATA_O[5:0] <= output_mode_second;
            `TPWM_IDX_STATUS: HRDATA_O[15:0] <= {dir_up, 1'b0, state, cnt};
            default: HRDATA_O <= 32'h00000000;
          endcase
        end
      end
    end
  end

  // Shared high-byte holder: written directly, or loaded by a low-byte read
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      temp_high <= 8'h00;
    end else if (dphase.valid && dphase.write && wdec.hit && wdec.hi) begin
      temp_high <= HWDATA_I[7:0];
    end else if (acc_valid && !HWRITE_I && addr_ok && rdec.hit && !rdec.hi) begin
      temp_high <= {4'h0, cmp_reg[rdec.k][11:8]};
    end
  end

  // Twelve-bit compare registers: the low-byte write commits both bytes
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      for (int i = 0; i < `TPWM_CMP_COUNT; i++) begin
        cmp_reg[i] <= `TPWM_RESET_CMP;
      end
    end else if (dphase.valid && dphase.write && wdec.hit && !wdec.hi) begin
      cmp_reg[wdec.k] <= {temp_high[3:0], HWDATA_I[7:0]};
    end
  end

  // Plain control registers
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      ctrl <= `TPWM_RESET_CTRL;
      config_reg <= `TPWM_RESET_CONFIG;
      output_configuration <= `TPWM_RESET_OUT;
      output_mode_second <= `TPWM_RESET_OUT;
    end else if (dphase.valid && dphase.write) begin
      case (dphase.idx)
        `TPWM_IDX_CTRL: ctrl <= HWDATA_I[5:0];
        `TPWM_IDX_CONFIG: config_reg <= HWDATA_I[3:0];
        `TPWM_IDX_OUTCFG: output_configuration <= HWDATA_I[5:0];
        `TPWM_IDX_OUTMODE2: output_mode_second <= HWDATA_I[5:0];
        default: ;
      endcase
    end
  end

  // Pin synchronisers; first stages feed only the second stages
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      pll_s1 <= 1'b0;
      pll_s2 <= 1'b0;
      pll_s3 <= 1'b0;
      em_s1 <= 3'h0;
      em_s2 <= 3'h0;
      hiz_s1 <= 1'b0;
      hiz_s2 <= 1'b0;
    end else begin
      pll_s1 <= PLL_CLK_I;
      pll_s2 <= pll_s1;
      pll_s3 <= pll_s2;
      em_s1 <= EMERGENCY_INPUT_I;
      em_s2 <= em_s1;
      hiz_s1 <= EMERGENCY_HIZ_CFG_I;
      hiz_s2 <= hiz_s1;
    end
  end

  assign emergency = |em_s2;

  // Counter tick: sampled external clock edges, or divided system clock
  // The external clock must be below a quarter of the system rate.
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      pre_cnt <= 8'h00;
    end else if (pre_cnt >= presc_limit(ctrl[`TPWM_CTRL_PRESC_HI:`TPWM_CTRL_PRESC_LO])) begin
      pre_cnt <= 8'h00;
    end else begin
      pre_cnt <= pre_cnt + 8'h01;
    end
  end

  always_comb begin
    if (ctrl[`TPWM_CTRL_CLK_SEL]) begin
      tick = pll_s2 && !pll_s3;
    end else begin
      tick = pre_cnt >= presc_limit(ctrl[`TPWM_CTRL_PRESC_HI:`TPWM_CTRL_PRESC_LO]);
    end
  end

  assign top = sh_cmp[`TPWM_CMP_TOP];

  // One-ramp ends at top; centered ends at top of the upward sweep
  always_comb begin
    if (ctrl[`TPWM_CTRL_CENTERED]) begin
      cyc_end = tick && dir_up && (cnt >= top);
    end else begin
      cyc_end = tick && (cnt >= top);
    end
  end

  // Run control: an early stop drops to idle at once, otherwise drain
  always_comb begin
    next_state = state;
    unique case (state)
      TPWM_IDLE: begin
        if (ctrl[`TPWM_CTRL_RUN]) begin
          next_state = TPWM_RUN;
        end
      end
      TPWM_RUN: begin
        if (!ctrl[`TPWM_CTRL_RUN]) begin
          if (ctrl[`TPWM_CTRL_CYCLE_STOP]) begin
            next_state = TPWM_DRAIN;
          end else begin
            next_state = TPWM_IDLE;
          end
        end
      end
      TPWM_DRAIN: begin
        if (ctrl[`TPWM_CTRL_RUN]) begin
          next_state = TPWM_RUN;
        end else if (cyc_end) begin
          next_state = TPWM_IDLE;
        end
      end
      default: next_state = TPWM_IDLE;
    endcase
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      state <= TPWM_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Shared counter; centered mode starts at top going down
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      cnt <= 12'h000;
      dir_up <= 1'b0;
    end else if (state == TPWM_IDLE) begin
      dir_up <= 1'b0;
      cnt <= ctrl[`TPWM_CTRL_CENTERED] ? top : 12'h000;
    end else if (next_state == TPWM_IDLE) begin
      dir_up <= 1'b0;
      cnt <= 12'h000;
    end else if (tick) begin
      if (!ctrl[`TPWM_CTRL_CENTERED]) begin
        cnt <= (cnt >= top) ? 12'h000 : cnt + 12'h001;
      end else if (!dir_up) begin
        if (cnt == 12'h000) begin
          dir_up <= 1'b1;
        end else begin
          cnt <= cnt - 12'h001;
        end
      end else if (cnt >= top) begin
        dir_up <= 1'b0;
        cnt <= (update_now && !config_reg[`TPWM_CFG_LOCK]) ? cmp_reg[`TPWM_CMP_TOP] : top;
      end else begin
        cnt <= cnt + 12'h001;
      end
    end
  end

  // Update is taken only at a cycle boundary or while stopped
  assign update_now = cyc_end || (state == TPWM_IDLE);

  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      sh_outcfg <= `TPWM_RESET_OUT;
      sh_mode2 <= `TPWM_RESET_OUT;
      for (int i = 0; i < `TPWM_CMP_COUNT; i++) begin
        sh_cmp[i] <= `TPWM_RESET_CMP;
      end
    end else if (update_now && !config_reg[`TPWM_CFG_LOCK]) begin
      sh_outcfg <= output_configuration;
      sh_mode2 <= output_mode_second;
      for (int i = 0; i < `TPWM_CMP_COUNT; i++) begin
        sh_cmp[i] <= cmp_reg[i];
      end
    end
  end

  // Per-module waveform, guard, polarity and emergency handling
  genvar n;
  generate
    for (n = 0; n < 3; n++) begin : g_mod
      logic [11:0] sa;
      logic [11:0] ra;
      logic [11:0] sb;
      logic raw_a;
      logic raw_b;
      logic guard_on;

      assign sa = sh_cmp[n*3];
      assign ra = cmp_reg[n*3+1]; // A reset is not lock-synchronised
      assign sb = sh_cmp[n*3+2];
      assign guard_on = !config_reg[`TPWM_CFG_OVL_LO+n];

      // Same mode bit drives every module
      always_comb begin
        if (state == TPWM_IDLE) begin
          raw_a = 1'b0;
          raw_b = 1'b0;
        end else if (ctrl[`TPWM_CTRL_CENTERED]) begin
          raw_a = cnt < sa;
          raw_b = cnt >= sb;
        end else begin
          raw_a = (cnt > sa) && (cnt <= ra);
          raw_b = (cnt > sb) && (cnt <= top);
        end
      end

      // Guard drops both when both would be on: safest for the bridge
      always_comb begin
        if (guard_on && raw_a && raw_b) begin
          want_a[n] = 1'b0;
          want_b[n] = 1'b0;
        end else begin
          want_a[n] = raw_a && sh_outcfg[n];
          want_b[n] = raw_b && sh_outcfg[n+3];
        end
      end

      // Registered pins; emergency forces inactive level or release
      always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
          STAGE_OUTPUT_A_O[n] <= 1'b0;
          STAGE_OUTPUT_B_O[n] <= 1'b0;
          STAGE_OUTPUT_A_OE_O[n] <= 1'b1;
          STAGE_OUTPUT_B_OE_O[n] <= 1'b1;
        end else begin
          STAGE_OUTPUT_A_O[n] <= (want_a[n] && !emergency) ^ sh_mode2[n];
          STAGE_OUTPUT_B_O[n] <= (want_b[n] && !emergency) ^ sh_mode2[n+3];
          STAGE_OUTPUT_A_OE_O[n] <= !(emergency && hiz_s2);
          STAGE_OUTPUT_B_OE_O[n] <= !(emergency && hiz_s2);
        end
      end
    end
  endgenerate

endmodule

// File: verif/tpwm_core_chk.sv
`timescale 1ns/1ns
module tpwm_core_chk
  import tpwm_pkg::*;
(
  input wire logic SYS_CLK_I,
  input wire logic RST_I,
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  input wire logic [31:0] HRDATA_O,
  input wire logic [2:0] EMERGENCY_INPUT_I,
  input wire logic EMERGENCY_HIZ_CFG_I,
  input wire logic [2:0] STAGE_OUTPUT_A_O,
  input wire logic [2:0] STAGE_OUTPUT_A_OE_O,
  input wire logic [2:0] STAGE_OUTPUT_B_O,
  input wire logic [2:0] STAGE_OUTPUT_B_OE_O
);
  logic a_v;
  logic a_w;
  logic [4:0] a_i;
  logic [7:0] tmp;
  logic [3:0] cfg;
  logic [5:0] m2;
  logic [5:0] ctl;
  logic [11:0] cmp [10];
  logic hit;
  logic [3:0] k;
  logic em_any;

  // Transfer whose data phase is now on the bus
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      a_v <= 1'b0;
    end else begin
      a_v <= HSEL_I & HTRANS_I[1] & HREADY_I;
    end
  end

  // Address only matters while a_v is set, so no reset needed
  always_ff @(posedge SYS_CLK_I) begin
    a_w <= HWRITE_I;
    a_i <= HADDR_I[6:2];
  end

  // Compare area decode
  assign hit = (a_i >= 5'h08) && (a_i <= 5'h1B);
  assign k = 4'((a_i - 5'h08) >> 1);
  assign em_any = |EMERGENCY_INPUT_I;

  // Shadow registers; one holder shared by all compares
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      tmp <= 8'h00;
      cfg <= 4'h0;
      m2 <= 6'h00;
      ctl <= 6'h00;
      for (int j = 0; j < 10; j++) begin
        cmp[j] <= 12'h000;
      end
    end else if (a_v && a_w) begin
      if (a_i == 5'h00) ctl <= HWDATA_I[5:0];
      if (a_i == 5'h01) cfg <= HWDATA_I[3:0];
      if (a_i == 5'h03) m2 <= HWDATA_I[5:0];
      if (hit && a_i[0]) tmp <= HWDATA_I[7:0];
      if (hit && !a_i[0]) cmp[k] <= {tmp[3:0], HWDATA_I[7:0]};
    end else if (a_v && hit && !a_i[0]) begin
      tmp <= {4'h0, cmp[k][11:8]};
    end
  end

  default clocking dc @(posedge SYS_CLK_I); endclocking
  default disable iff (RST_I);

  chk_reset_idle: assert property ($fell(RST_I) |->
    STAGE_OUTPUT_A_O == 3'h0 && STAGE_OUTPUT_B_O == 3'h0
    && &STAGE_OUTPUT_A_OE_O && &STAGE_OUTPUT_B_OE_O) else $error("outputs not idle after reset");
  chk_guard_excl: assert property (m2 == 6'h00 |->
    (STAGE_OUTPUT_A_O & STAGE_OUTPUT_B_O & ~cfg[3:1]) == 3'h0) else $error("guarded overlap");
  chk_emerg_hiz: assert property ((em_any && EMERGENCY_HIZ_CFG_I)[*5] |->
    STAGE_OUTPUT_A_OE_O == 3'h0 && STAGE_OUTPUT_B_OE_O == 3'h0) else $error("pins not released");
  chk_emerg_level: assert property ((em_any && !EMERGENCY_HIZ_CFG_I)[*5] |->
    STAGE_OUTPUT_A_O == m2[2:0] && STAGE_OUTPUT_B_O == m2[5:3] && &STAGE_OUTPUT_A_OE_O)
    else $error("emergency level wrong");
  chk_oe_cause: assert property ((STAGE_OUTPUT_A_OE_O != 3'h7 || STAGE_OUTPUT_B_OE_O != 3'h7) |->
    $past(em_any, 3) || $past(em_any, 4)) else $error("pins released without emergency");
  chk_low_read: assert property (a_v && !a_w && hit && !a_i[0] |->
    HRDATA_O[7:0] == cmp[k][7:0]) else $error("low byte read wrong");
  chk_holder_read: assert property (a_v && !a_w && hit && a_i[0] |->
    HRDATA_O[7:0] == tmp) else $error("holder read wrong");
  // Centered idle parks the counter at top, so only one-ramp idle reads zero
  chk_idle_count: assert property (a_v && !a_w && a_i == 5'h04 && HRDATA_O[13:12] == 2'h0
    && !ctl[1] |->
    HRDATA_O[11:0] == 12'h000) else $error("idle counter not zero");
endmodule

bind tpwm_core tpwm_core_chk u_chk (.SYS_CLK_I, .RST_I, .HSEL_I, .HADDR_I, .HTRANS_I, .HWRITE_I,
  .HWDATA_I, .HREADY_I, .HRDATA_O, .EMERGENCY_INPUT_I, .EMERGENCY_HIZ_CFG_I, .STAGE_OUTPUT_A_O,
  .STAGE_OUTPUT_A_OE_O, .STAGE_OUTPUT_B_O, .STAGE_OUTPUT_B_OE_O);

// File: verif/tpwm_bridge_model.sv
`timescale 1ns/1ns
// Gate driver inputs of the three half-bridges
module tpwm_bridge_model
  import tpwm_pkg::*;
(
  input wire logic [2:0] a_i,
  input wire logic [2:0] a_oe_i,
  input wire logic [2:0] b_i,
  input wire logic [2:0] b_oe_i,
  output logic [2:0] gate_a_o,
  output logic [2:0] gate_b_o
);
  // Pull-downs keep a released input off, never a stale level
  assign gate_a_o = a_i & a_oe_i;
  assign gate_b_o = b_i & b_oe_i;
endmodule

// File: verif/three_phase_pwm_waveform_core_tb.sv
`timescale 1ns/1ns
module three_phase_pwm_waveform_core_tb import tpwm_pkg::*;;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b1;
  logic hwrite = 1'b0;
  logic pll = 1'b0;
  logic hiz = 1'b0;
  logic hready;
  logic hresp;
  logic [1:0] htrans = 2'h0;
  logic [2:0] em = 3'h0;
  logic [2:0] oa, oae, ob, obe, ga, gb;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, q;
  logic [11:0] v;
  logic [15:0] r;
  int errors = 0;
  int checked = 0;
  int cyc = 0;
  int seed = 10;
  int sa, ra, sb, top, per, ca, cb, cab, re;
  int dv [5] = '{1, 4, 32, 256, 8};

  tpwm_core u_dut (.SYS_CLK_I(clk), .RST_I(rst), .HSEL_I(hsel), .HADDR_I(haddr),
    .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready),
    .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp), .PLL_CLK_I(pll),
    .EMERGENCY_INPUT_I(em), .EMERGENCY_HIZ_CFG_I(hiz), .STAGE_OUTPUT_A_O(oa),
    .STAGE_OUTPUT_A_OE_O(oae), .STAGE_OUTPUT_B_O(ob), .STAGE_OUTPUT_B_OE_O(obe));
  tpwm_bridge_model u_br (.a_i(oa), .a_oe_i(oae), .b_i(ob), .b_oe_i(obe), .gate_a_o(ga),
    .gate_b_o(gb));

  // PLL stand-in at 1/8 of the system rate, edges on falling system edges, clear of rising ones
  always #5 clk = ~clk;
  always #40 pll = ~pll;

  // Ceiling covers the divide-by-256 sweep with margin
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      errors++;
      $display("[ERR] %0t timeout", $time);
      test_done();
    end
  end

  task test_done();
    if (errors == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask

  // One single AHB transfer; hready is waited for, never assumed
  task xfer(input logic w, input logic [4:0] i, input logic [7:0] d);
    @(posedge clk);
    htrans <= 2'h2;
    haddr <= {25'h0, i, 2'h0};
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge clk); while (hready !== 1'b1);
    q = hrdata;
  endtask

  task wr16(input int k, input logic [11:0] d);
    xfer(1'b1, 5'(9 + 2 * k), {4'h0, d[11:8]});
    xfer(1'b1, 5'(8 + 2 * k), d[7:0]);
  endtask

  task rd16(input int k);
    xfer(1'b0, 5'(8 + 2 * k), 8'h00);
    r[7:0] = q[7:0];
    xfer(1'b0, 5'(9 + 2 * k), 8'h00);
    r[15:8] = q[7:0];
  endtask

  // Window of whole periods, so phase does not matter
  task meas(input int n, input int m);
    logic p;
    ca = 0;
    cb = 0;
    cab = 0;
    re = 0;
    p = ga[m];
    repeat (n) begin
      @(negedge clk);
      ca += ga[m];
      cb += gb[m];
      cab += ga[m] & gb[m];
      re += ga[m] & !p;
      p = ga[m];
    end
  endtask

  task wave(input bit c, input int div, input int k, input int m);
    per = c ? 2 * (top + 1) : top + 1;
    repeat (3 * per * div) @(posedge clk);
    meas(k * per * div, m);
  endtask

  function automatic int on_a(input bit c);
    return c ? 2 * sa : ra - sa;
  endfunction

  function automatic int on_b(input bit c);
    return c ? 2 * (top - sb + 1) : top - sb;
  endfunction

  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    xfer(1'b0, 5'h04, 8'h00);
    chk(q[13:0], 0);
    chk({oa, ob, oae, obe, hresp}, 32'h7E);
    xfer(1'b0, 5'h05, 8'h00);
    chk(q, 0);
    v = 12'($random(seed));
    wr16(4, v);
    rd16(4);
    chk(r, {4'h0, v});
    xfer(1'b1, 5'h09, 8'h5A);
    xfer(1'b0, 5'h17, 8'h00);
    chk(q[7:0], 8'h5A);
    sa = 1 + {$random(seed)} % 4;
    ra = sa + 2 + {$random(seed)} % 4;
    sb = ra + 1 + {$random(seed)} % 4;
    top = sb + 2 + {$random(seed)} % 8;
    for (int m = 0; m < 3; m++) begin
      wr16(3 * m, 12'(sa));
      wr16(3 * m + 1, 12'(ra));
      wr16(3 * m + 2, 12'(sb));
    end
    wr16(9, 12'(top));
    xfer(1'b1, 5'h02, 8'h3F);
    // Every prescale step, then the PLL clock
    for (int i = 0; i < 5; i++) begin
      xfer(1'b1, 5'h00, i < 4 ? 8'(1 + 16 * i) : 8'h09);
      wave(0, dv[i], 1, 0);
      chk(ca, on_a(0) * dv[i]);
      chk(cb, on_b(0) * dv[i]);
      chk(cab, 0);
      chk(re, 1);
    end
    // Centered; A reset of module 2 moved to show it is unused
    wr16(7, 12'h000);
    xfer(1'b1, 5'h00, 8'h03);
    wave(1, 1, 2, 2);
    chk(ca, 2 * on_a(1));
    chk(cb, 2 * on_b(1));
    chk(re, 2);
    xfer(1'b1, 5'h01, 8'h01);
    wr16(9, 12'(top + 4));
    wave(1, 1, 2, 0);
    chk(cb, 2 * on_b(1));
    xfer(1'b1, 5'h01, 8'h00);
    top = top + 4;
    wave(1, 1, 2, 0);
    chk(cb, 2 * on_b(1));
    chk(re, 2);
    // Immediate stop, fresh start, then stop at cycle end
    xfer(1'b1, 5'h00, 8'h02);
    xfer(1'b0, 5'h04, 8'h00);
    chk(q[13:0], 0);
    xfer(1'b1, 5'h00, 8'h03);
    xfer(1'b1, 5'h00, 8'h06);
    xfer(1'b0, 5'h04, 8'h00);
    chk(q[13:12], 2'h3);
    repeat (per) @(posedge clk);
    xfer(1'b0, 5'h04, 8'h00);
    // Drained in centered mode: idle, counter parked at top for a fresh start
    chk(q[13:0], top);
    // Overlapping compares on module 0, guard on then off
    xfer(1'b1, 5'h00, 8'h01);
    wr16(2, 12'(sa + 1));
    wave(0, 1, 2, 0);
    chk(cab, 0);
    xfer(1'b1, 5'h01, 8'h02);
    wave(0, 1, 2, 0);
    chk(cab, 2 * (ra - sa - 1));
    chk(cb, 2 * (top - sa - 1));
    xfer(1'b1, 5'h03, 8'h01);
    wave(0, 1, 2, 0);
    chk(ca, 2 * (per - ra + sa));
    // Disabled A of module 0 sits at its inactive level, high when active-low
    xfer(1'b1, 5'h02, 8'h3E);
    wave(0, 1, 1, 0);
    chk(ca, per);
    @(posedge clk);
    em <= 3'h2;
    hiz <= 1'b1;
    repeat (8) @(posedge clk);
    chk({oae, obe, ga, gb}, 0);
    hiz <= 1'b0;
    repeat (8) @(posedge clk);
    chk({oae, obe, oa, ob}, 32'hFC8);
    em <= 3'h0;
    test_done();
  end
endmodule
